// [hdl/scif_event_flags.sv]
// Clock/power event flags: sticky flags, enables, interrupt request.
// Assumes live status inputs synchronous to clk and a plain register port.
//
// Notes on behaviour
// - Writing one sets the crystal-ready enable
// - Enabled crystal-ready flag raises interrupt request
// - Reserved bits read zero; writes ignored
// - PLL timeout flag sets on rising status
// - PLL lock lost/gained flags set on rise
// - Brown-out flags set on rising status
// - FLL reference-stopped flag sets on rise
// - FLL coarse/fine lock flags set on rise
// - FLL out-of-bounds/ready flags set on rise
// - Oscillator ready flags set on rising status
// - Write one clears flag; zero keeps it
// - Request while flag and same enable set
// - Flags may be set at start; software clears
// - Live status visible as read-only register
// - Enable set and clear share one store
//
// The plain strobed port was decided locally.
`default_nettype none
`include "scif_defines.svh"

module scif_event_flags (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	// Live status conditions
	input  wire logic [31:0] liveStatus,
	// Startup presets, taken once after reset release
	input  wire logic [31:0] startupFlags,
	// Interrupt
	output logic             irq
);

	typedef struct packed {
		logic [31:0] flags;
		logic [31:0] enable;
		logic [31:0] rdata;
		logic        started;
	} scif_flags_state_t;

	scif_flags_state_t   state;
	scif_flags_state_t   next_state;
	scif_pkg::scif_sel_t sel;
	logic [31:0]         rise;
	logic [31:0]         liveMasked;
	logic [31:0]         presetVec;
	logic [31:0]         setVec;
	logic [31:0]         clrVec;
	logic [31:0]         enSetVec;
	logic [31:0]         enClrVec;
	logic [31:0]         reqVec;
	logic                firstEdge;
	logic                flagWrite;
	logic                enSetWrite;
	logic                enClrWrite;

	// Write strobe aimed at one register; shared by every write path
	function automatic logic isWriteTo(
		input logic                wrIn,
		input scif_pkg::scif_sel_t selIn,
		input scif_pkg::scif_sel_t target
	);
		return wrIn && (selIn == target);
	endfunction : isWriteTo

	// Trim to implemented bits so reserved positions never report
	function automatic logic [31:0] implBits(
		input logic [31:0] value
	);
		return value & `SCIF_IMPL_MASK;
	endfunction : implBits

	// Reserved bits never store or report anything
	assign liveMasked = implBits(liveStatus);

	scif_addr_decode u_decode (
		.addr (addr),
		.sel  (sel)
	);

	// One detector covers every flag source
	scif_edge_detect #(
		.WIDTH (32)
	) u_edge (
		.clk   (clk),
		.nrst  (nrst),
		.level (liveMasked),
		.rise  (rise)
	);

	// Write decode and first-edge marker
	assign firstEdge  = !state.started;
	assign flagWrite  = isWriteTo(wr, sel, scif_pkg::SCIF_FLAGS);
	assign enSetWrite = isWriteTo(wr, sel, scif_pkg::SCIF_ENSET);
	assign enClrWrite = isWriteTo(wr, sel, scif_pkg::SCIF_ENCLR);

	// Fuse presets, applied on the first edge after reset only
	// Main crystal ready
	assign presetVec[`SCIF_BIT_XOSC] = firstEdge & startupFlags[`SCIF_BIT_XOSC];
	// 32 kHz crystal ready
	assign presetVec[`SCIF_BIT_XOSC32K] = firstEdge & startupFlags[`SCIF_BIT_XOSC32K];
	// 32 kHz internal oscillator ready
	assign presetVec[`SCIF_BIT_OSC32K] = firstEdge & startupFlags[`SCIF_BIT_OSC32K];
	// 8 MHz internal oscillator ready
	assign presetVec[`SCIF_BIT_OSC8M] = firstEdge & startupFlags[`SCIF_BIT_OSC8M];
	// FLL ready
	assign presetVec[`SCIF_BIT_FLLRDY] = firstEdge & startupFlags[`SCIF_BIT_FLLRDY];
	// FLL out of bounds
	assign presetVec[`SCIF_BIT_FLLOOB] = firstEdge & startupFlags[`SCIF_BIT_FLLOOB];
	// FLL fine lock
	assign presetVec[`SCIF_BIT_FLLFINE] = firstEdge & startupFlags[`SCIF_BIT_FLLFINE];
	// FLL coarse lock
	assign presetVec[`SCIF_BIT_FLLCOARSE] = firstEdge & startupFlags[`SCIF_BIT_FLLCOARSE];
	// FLL reference stopped
	assign presetVec[`SCIF_BIT_FLLRCS] = firstEdge & startupFlags[`SCIF_BIT_FLLRCS];
	// Brown-out ready
	assign presetVec[`SCIF_BIT_BORDY] = firstEdge & startupFlags[`SCIF_BIT_BORDY];
	// Brown-out detected
	assign presetVec[`SCIF_BIT_BODET] = firstEdge & startupFlags[`SCIF_BIT_BODET];
	// Brown-out sync ready
	assign presetVec[`SCIF_BIT_BOSYNC] = firstEdge & startupFlags[`SCIF_BIT_BOSYNC];
	// PLL lock gained
	assign presetVec[`SCIF_BIT_PLLGAIN] = firstEdge & startupFlags[`SCIF_BIT_PLLGAIN];
	// PLL lock lost
	assign presetVec[`SCIF_BIT_PLLLOST] = firstEdge & startupFlags[`SCIF_BIT_PLLLOST];
	// PLL lock timeout
	assign presetVec[`SCIF_BIT_PLLTO] = firstEdge & startupFlags[`SCIF_BIT_PLLTO];
	assign presetVec[31:18] = 14'h0000;
	assign presetVec[14:12] = 3'h0;

	// Per-source events; zero history means a level high at start counts
	// Main crystal ready
	assign setVec[`SCIF_BIT_XOSC] = rise[`SCIF_BIT_XOSC];
	// 32 kHz crystal ready
	assign setVec[`SCIF_BIT_XOSC32K] = rise[`SCIF_BIT_XOSC32K];
	// 32 kHz internal oscillator ready
	assign setVec[`SCIF_BIT_OSC32K] = rise[`SCIF_BIT_OSC32K];
	// 8 MHz internal oscillator ready
	assign setVec[`SCIF_BIT_OSC8M] = rise[`SCIF_BIT_OSC8M];
	// FLL ready
	assign setVec[`SCIF_BIT_FLLRDY] = rise[`SCIF_BIT_FLLRDY];
	// FLL out of bounds
	assign setVec[`SCIF_BIT_FLLOOB] = rise[`SCIF_BIT_FLLOOB];
	// FLL fine lock
	assign setVec[`SCIF_BIT_FLLFINE] = rise[`SCIF_BIT_FLLFINE];
	// FLL coarse lock
	assign setVec[`SCIF_BIT_FLLCOARSE] = rise[`SCIF_BIT_FLLCOARSE];
	// FLL reference stopped
	assign setVec[`SCIF_BIT_FLLRCS] = rise[`SCIF_BIT_FLLRCS];
	// Brown-out ready
	assign setVec[`SCIF_BIT_BORDY] = rise[`SCIF_BIT_BORDY];
	// Brown-out detected
	assign setVec[`SCIF_BIT_BODET] = rise[`SCIF_BIT_BODET];
	// Brown-out sync ready
	assign setVec[`SCIF_BIT_BOSYNC] = rise[`SCIF_BIT_BOSYNC];
	// PLL lock gained
	assign setVec[`SCIF_BIT_PLLGAIN] = rise[`SCIF_BIT_PLLGAIN];
	// PLL lock lost
	assign setVec[`SCIF_BIT_PLLLOST] = rise[`SCIF_BIT_PLLLOST];
	// PLL lock timeout
	assign setVec[`SCIF_BIT_PLLTO] = rise[`SCIF_BIT_PLLTO];
	assign setVec[31:18] = 14'h0000;
	assign setVec[14:12] = 3'h0;

	// Write-one clears; a zero bit leaves its flag alone
	// Main crystal ready
	assign clrVec[`SCIF_BIT_XOSC] = flagWrite & wdata[`SCIF_BIT_XOSC];
	// 32 kHz crystal ready
	assign clrVec[`SCIF_BIT_XOSC32K] = flagWrite & wdata[`SCIF_BIT_XOSC32K];
	// 32 kHz internal oscillator ready
	assign clrVec[`SCIF_BIT_OSC32K] = flagWrite & wdata[`SCIF_BIT_OSC32K];
	// 8 MHz internal oscillator ready
	assign clrVec[`SCIF_BIT_OSC8M] = flagWrite & wdata[`SCIF_BIT_OSC8M];
	// FLL ready
	assign clrVec[`SCIF_BIT_FLLRDY] = flagWrite & wdata[`SCIF_BIT_FLLRDY];
	// FLL out of bounds
	assign clrVec[`SCIF_BIT_FLLOOB] = flagWrite & wdata[`SCIF_BIT_FLLOOB];
	// FLL fine lock
	assign clrVec[`SCIF_BIT_FLLFINE] = flagWrite & wdata[`SCIF_BIT_FLLFINE];
	// FLL coarse lock
	assign clrVec[`SCIF_BIT_FLLCOARSE] = flagWrite & wdata[`SCIF_BIT_FLLCOARSE];
	// FLL reference stopped
	assign clrVec[`SCIF_BIT_FLLRCS] = flagWrite & wdata[`SCIF_BIT_FLLRCS];
	// Brown-out ready
	assign clrVec[`SCIF_BIT_BORDY] = flagWrite & wdata[`SCIF_BIT_BORDY];
	// Brown-out detected
	assign clrVec[`SCIF_BIT_BODET] = flagWrite & wdata[`SCIF_BIT_BODET];
	// Brown-out sync ready
	assign clrVec[`SCIF_BIT_BOSYNC] = flagWrite & wdata[`SCIF_BIT_BOSYNC];
	// PLL lock gained
	assign clrVec[`SCIF_BIT_PLLGAIN] = flagWrite & wdata[`SCIF_BIT_PLLGAIN];
	// PLL lock lost
	assign clrVec[`SCIF_BIT_PLLLOST] = flagWrite & wdata[`SCIF_BIT_PLLLOST];
	// PLL lock timeout
	assign clrVec[`SCIF_BIT_PLLTO] = flagWrite & wdata[`SCIF_BIT_PLLTO];
	assign clrVec[31:18] = 14'h0000;
	assign clrVec[14:12] = 3'h0;

	// Enable set bits; software never needs a read-modify-write
	// Main crystal ready
	assign enSetVec[`SCIF_BIT_XOSC] = enSetWrite & wdata[`SCIF_BIT_XOSC];
	// 32 kHz crystal ready
	assign enSetVec[`SCIF_BIT_XOSC32K] = enSetWrite & wdata[`SCIF_BIT_XOSC32K];
	// 32 kHz internal oscillator ready
	assign enSetVec[`SCIF_BIT_OSC32K] = enSetWrite & wdata[`SCIF_BIT_OSC32K];
	// 8 MHz internal oscillator ready
	assign enSetVec[`SCIF_BIT_OSC8M] = enSetWrite & wdata[`SCIF_BIT_OSC8M];
	// FLL ready
	assign enSetVec[`SCIF_BIT_FLLRDY] = enSetWrite & wdata[`SCIF_BIT_FLLRDY];
	// FLL out of bounds
	assign enSetVec[`SCIF_BIT_FLLOOB] = enSetWrite & wdata[`SCIF_BIT_FLLOOB];
	// FLL fine lock
	assign enSetVec[`SCIF_BIT_FLLFINE] = enSetWrite & wdata[`SCIF_BIT_FLLFINE];
	// FLL coarse lock
	assign enSetVec[`SCIF_BIT_FLLCOARSE] = enSetWrite & wdata[`SCIF_BIT_FLLCOARSE];
	// FLL reference stopped
	assign enSetVec[`SCIF_BIT_FLLRCS] = enSetWrite & wdata[`SCIF_BIT_FLLRCS];
	// Brown-out ready
	assign enSetVec[`SCIF_BIT_BORDY] = enSetWrite & wdata[`SCIF_BIT_BORDY];
	// Brown-out detected
	assign enSetVec[`SCIF_BIT_BODET] = enSetWrite & wdata[`SCIF_BIT_BODET];
	// Brown-out sync ready
	assign enSetVec[`SCIF_BIT_BOSYNC] = enSetWrite & wdata[`SCIF_BIT_BOSYNC];
	// PLL lock gained
	assign enSetVec[`SCIF_BIT_PLLGAIN] = enSetWrite & wdata[`SCIF_BIT_PLLGAIN];
	// PLL lock lost
	assign enSetVec[`SCIF_BIT_PLLLOST] = enSetWrite & wdata[`SCIF_BIT_PLLLOST];
	// PLL lock timeout
	assign enSetVec[`SCIF_BIT_PLLTO] = enSetWrite & wdata[`SCIF_BIT_PLLTO];
	assign enSetVec[31:18] = 14'h0000;
	assign enSetVec[14:12] = 3'h0;

	// Enable clear bits act on the same store as the set path
	// Main crystal ready
	assign enClrVec[`SCIF_BIT_XOSC] = enClrWrite & wdata[`SCIF_BIT_XOSC];
	// 32 kHz crystal ready
	assign enClrVec[`SCIF_BIT_XOSC32K] = enClrWrite & wdata[`SCIF_BIT_XOSC32K];
	// 32 kHz internal oscillator ready
	assign enClrVec[`SCIF_BIT_OSC32K] = enClrWrite & wdata[`SCIF_BIT_OSC32K];
	// 8 MHz internal oscillator ready
	assign enClrVec[`SCIF_BIT_OSC8M] = enClrWrite & wdata[`SCIF_BIT_OSC8M];
	// FLL ready
	assign enClrVec[`SCIF_BIT_FLLRDY] = enClrWrite & wdata[`SCIF_BIT_FLLRDY];
	// FLL out of bounds
	assign enClrVec[`SCIF_BIT_FLLOOB] = enClrWrite & wdata[`SCIF_BIT_FLLOOB];
	// FLL fine lock
	assign enClrVec[`SCIF_BIT_FLLFINE] = enClrWrite & wdata[`SCIF_BIT_FLLFINE];
	// FLL coarse lock
	assign enClrVec[`SCIF_BIT_FLLCOARSE] = enClrWrite & wdata[`SCIF_BIT_FLLCOARSE];
	// FLL reference stopped
	assign enClrVec[`SCIF_BIT_FLLRCS] = enClrWrite & wdata[`SCIF_BIT_FLLRCS];
	// Brown-out ready
	assign enClrVec[`SCIF_BIT_BORDY] = enClrWrite & wdata[`SCIF_BIT_BORDY];
	// Brown-out detected
	assign enClrVec[`SCIF_BIT_BODET] = enClrWrite & wdata[`SCIF_BIT_BODET];
	// Brown-out sync ready
	assign enClrVec[`SCIF_BIT_BOSYNC] = enClrWrite & wdata[`SCIF_BIT_BOSYNC];
	// PLL lock gained
	assign enClrVec[`SCIF_BIT_PLLGAIN] = enClrWrite & wdata[`SCIF_BIT_PLLGAIN];
	// PLL lock lost
	assign enClrVec[`SCIF_BIT_PLLLOST] = enClrWrite & wdata[`SCIF_BIT_PLLLOST];
	// PLL lock timeout
	assign enClrVec[`SCIF_BIT_PLLTO] = enClrWrite & wdata[`SCIF_BIT_PLLTO];
	assign enClrVec[31:18] = 14'h0000;
	assign enClrVec[14:12] = 3'h0;

	// Per-flag requests, merged into the one level output
	// Main crystal ready
	assign reqVec[`SCIF_BIT_XOSC] = state.flags[`SCIF_BIT_XOSC] & state.enable[`SCIF_BIT_XOSC];
	// 32 kHz crystal ready
	assign reqVec[`SCIF_BIT_XOSC32K] = state.flags[1] & state.enable[1];
	// 32 kHz internal oscillator ready
	assign reqVec[`SCIF_BIT_OSC32K] = state.flags[2] & state.enable[2];
	// 8 MHz internal oscillator ready
	assign reqVec[`SCIF_BIT_OSC8M] = state.flags[3] & state.enable[3];
	// FLL ready
	assign reqVec[`SCIF_BIT_FLLRDY] = state.flags[4] & state.enable[4];
	// FLL out of bounds
	assign reqVec[`SCIF_BIT_FLLOOB] = state.flags[5] & state.enable[5];
	// FLL fine lock
	assign reqVec[`SCIF_BIT_FLLFINE] = state.flags[6] & state.enable[6];
	// FLL coarse lock
	assign reqVec[`SCIF_BIT_FLLCOARSE] = state.flags[7] & state.enable[7];
	// FLL reference stopped
	assign reqVec[`SCIF_BIT_FLLRCS] = state.flags[8] & state.enable[8];
	// Brown-out ready
	assign reqVec[`SCIF_BIT_BORDY] = state.flags[9] & state.enable[9];
	// Brown-out detected
	assign reqVec[`SCIF_BIT_BODET] = state.flags[10] & state.enable[10];
	// Brown-out sync ready
	assign reqVec[`SCIF_BIT_BOSYNC] = state.flags[11] & state.enable[11];
	// PLL lock gained
	assign reqVec[`SCIF_BIT_PLLGAIN] = state.flags[15] & state.enable[15];
	// PLL lock lost
	assign reqVec[`SCIF_BIT_PLLLOST] = state.flags[16] & state.enable[16];
	// PLL lock timeout
	assign reqVec[`SCIF_BIT_PLLTO] = state.flags[17] & state.enable[17];
	assign reqVec[31:18] = 14'h0000;
	assign reqVec[14:12] = 3'h0;

	// Next register state
	always_comb begin
		next_state = state;
		next_state.started = 1'b1;
		// Clear first, then set, so a same-cycle edge survives
		next_state.flags = state.flags & ~clrVec;
		next_state.flags = next_state.flags | setVec | presetVec;
		next_state.enable = state.enable | enSetVec;
		next_state.enable = next_state.enable & ~enClrVec;
		// Read data registered; unmapped offsets answer zero
		next_state.rdata = 32'h0000_0000;
		if (rd) begin
			case (sel)
				scif_pkg::SCIF_ENCLR: begin
					next_state.rdata = state.enable;
				end
				scif_pkg::SCIF_ENSET: begin
					next_state.rdata = state.enable;
				end
				scif_pkg::SCIF_FLAGS: begin
					next_state.rdata = implBits(state.flags);
				end
				scif_pkg::SCIF_LIVE: begin
					next_state.rdata = liveMasked;
				end
				default: begin
					next_state.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state.flags   <= `SCIF_FLAGS_RESET;
			state.enable  <= `SCIF_EN_RESET;
			state.rdata   <= 32'h0000_0000;
			state.started <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign rdata = state.rdata;
	// Level request while any enabled flag stands
	assign irq = |reqVec;

endmodule : scif_event_flags

`default_nettype wire

// [inc/scif_defines.svh]
// Offsets, field positions and reset values of the clock/power event flag block.
// Assumes inclusion by bare name from any design or bench file.
`ifndef SCIF_DEFINES_SVH
`define SCIF_DEFINES_SVH

// Register offsets (byte addresses)
`define SCIF_OFF_ENCLR     8'h04
`define SCIF_OFF_ENSET     8'h05
`define SCIF_OFF_FLAGS     8'h08
`define SCIF_OFF_LIVE      8'h0C
`define SCIF_ADDR_W        8

// Flag field positions
`define SCIF_BIT_XOSC      0
`define SCIF_BIT_XOSC32K   1
`define SCIF_BIT_OSC32K    2
`define SCIF_BIT_OSC8M     3
`define SCIF_BIT_FLLRDY    4
`define SCIF_BIT_FLLOOB    5
`define SCIF_BIT_FLLFINE   6
`define SCIF_BIT_FLLCOARSE 7
`define SCIF_BIT_FLLRCS    8
`define SCIF_BIT_BORDY     9
`define SCIF_BIT_BODET     10
`define SCIF_BIT_BOSYNC    11
`define SCIF_BIT_PLLGAIN   15
`define SCIF_BIT_PLLLOST   16
`define SCIF_BIT_PLLTO     17

// Implemented bits: 17:15 and 11:0
`define SCIF_IMPL_MASK     32'h0003_8FFF
`define SCIF_FLAGS_RESET   32'h0000_0000
`define SCIF_EN_RESET      32'h0000_0000
`define SCIF_FLAG_W        18

`endif

// [inc/scif_pkg.sv]
// Types for the clock/power event flag block.
// Assumes scif_defines.svh is compiled alongside.
`default_nettype none

package scif_pkg;

	// Register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} scif_req_t;

	// Access kind decoded from the offset
	typedef enum logic [2:0] {
		SCIF_NONE,
		SCIF_ENCLR,
		SCIF_ENSET,
		SCIF_FLAGS,
		SCIF_LIVE
	} scif_sel_t;

endpackage : scif_pkg

`default_nettype wire

// [hdl/scif_edge_detect.sv]
// Rising-edge detector for the live status vector.
// Assumes status inputs are synchronous to clk.
`default_nettype none
`include "scif_defines.svh"

module scif_edge_detect #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// Status in, edge pulses out
	input  wire logic [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);

	typedef struct packed {
		logic [WIDTH-1:0] prev;
	} scif_edge_state_t;

	scif_edge_state_t state;
	scif_edge_state_t next_state;

	// Previous sample; reset to zero so a high level at start counts as edge
	always_comb begin
		next_state.prev = level;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Edge pulse, one cycle
	assign rise = level & ~state.prev;

endmodule : scif_edge_detect

`default_nettype wire

// [hdl/scif_addr_decode.sv]
// Offset decoder for the event flag register port.
// Assumes offsets from scif_defines.svh.
`default_nettype none
`include "scif_defines.svh"

module scif_addr_decode (
	// Offset in
	input  wire logic [7:0]       addr,
	// Decoded register
	output scif_pkg::scif_sel_t   sel
);

	// Priority chain over known offsets
	always_comb begin
		if (addr == `SCIF_OFF_ENCLR) begin
			sel = scif_pkg::SCIF_ENCLR;
		end else if (addr == `SCIF_OFF_ENSET) begin
			sel = scif_pkg::SCIF_ENSET;
		end else if (addr == `SCIF_OFF_FLAGS) begin
			sel = scif_pkg::SCIF_FLAGS;
		end else if (addr == `SCIF_OFF_LIVE) begin
			sel = scif_pkg::SCIF_LIVE;
		end else begin
			sel = scif_pkg::SCIF_NONE;
		end
	end

endmodule : scif_addr_decode

`default_nettype wire

// [testbench/scif_event_flags_asserts.sv]
// Port-level checker for the event flag block.
// Assumes live status is synchronous to clk; bound onto every flag block.
`default_nettype none
`include "scif_defines.svh"

module scif_event_flags_asserts (
	// Clock and reset
	input wire logic		clk,
	input wire logic		nrst,
	// Register port
	input wire logic [7:0]	addr,
	input wire logic [31:0]	wdata,
	input wire logic		wr,
	input wire logic		rd,
	input wire logic [31:0]	rdata,
	// Status and interrupt
	input wire logic [31:0]	liveStatus,
	input wire logic [31:0]	startupFlags,
	input wire logic		irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Own status history, cleared by reset like the block's
	logic [31:0] prevLive;
	logic [31:0] rise;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) prevLive <= 32'h0000_0000;
		else prevLive <= liveStatus;
	end
	assign rise = liveStatus & ~prevLive & `SCIF_IMPL_MASK;
	sequence s_rdf; rd && addr == `SCIF_OFF_FLAGS; endsequence
	sequence s_wen; wr && addr == `SCIF_OFF_ENSET; endsequence
	property p_idle; !rd |=> rdata == 32'h0000_0000; endproperty
	property p_resv; (rdata & ~`SCIF_IMPL_MASK) == 32'h0000_0000; endproperty
	property p_live;
		rd && addr == `SCIF_OFF_LIVE |=> rdata == ($past(liveStatus) & `SCIF_IMPL_MASK);
	endproperty
	// Edge wins even against a clear in the same cycle
	property p_rise;
		(rise != 0) ##1 s_rdf |=> (rdata & $past(rise, 2)) == $past(rise, 2);
	endproperty
	property p_clr;
		wr && addr == `SCIF_OFF_FLAGS && wdata == `SCIF_IMPL_MASK && rise == 0 |=> !irq;
	endproperty
	property p_enset; s_wen ##0 wdata[0] ##1 rd && addr == `SCIF_OFF_ENCLR |=> rdata[0];
	endproperty
	property p_irq; s_rdf ##1 s_wen ##0 (wdata == `SCIF_IMPL_MASK && rdata != 0) |=> irq;
	endproperty
	property p_keep;
		s_rdf ##1 (wr && addr == `SCIF_OFF_FLAGS && wdata == 0) ##1 s_rdf
			|=> (rdata & $past(rdata, 2)) == $past(rdata, 2);
	endproperty
	a_idle: assert property (p_idle) else $error("read data not idle");
	a_resv: assert property (p_resv) else $error("reserved bits read one");
	a_live: assert property (p_live) else $error("live status read wrong");
	a_rise: assert property (p_rise) else $error("rising status lost");
	a_clr: assert property (p_clr) else $error("irq after full clear");
	a_enset: assert property (p_enset) else $error("enable not set");
	a_irq: assert property (p_irq) else $error("irq missing");
	a_keep: assert property (p_keep) else $error("zero write cleared");
endmodule : scif_event_flags_asserts

bind scif_event_flags scif_event_flags_asserts chk_u (.clk, .nrst, .addr, .wdata, .wr, .rd,
	.rdata, .liveStatus, .startupFlags, .irq);

`default_nettype wire

// [testbench/sysctrl_interrupt_flags_tb_top.sv]
// Self-checking bench for the event flag block.
// Assumes the checker is bound; startup preset sets one flag.
`default_nettype none
`include "scif_defines.svh"

module sysctrl_interrupt_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic			clk, nrst, wr, rd, irq;
	logic [7:0]		addr;
	logic [31:0]	wdata, rdata, liveStatus, startupFlags;
	int				failures = 0, comparisons = 0, cycles = 0;
	scif_event_flags dut_u (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .liveStatus,
		.startupFlags, .irq);
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			summarize();
		end
	end
	task automatic summarize();
		if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk
	task automatic bus(logic w, logic r, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask : bus
	// Read data stand only in the cycle after the strobe
	task automatic rdChk(string name, logic [7:0] a, logic [31:0] exp);
		bus(0, 1, a, 0);
		bus(0, 0, a, 0);
		#1 chk(name, exp, rdata);
	endtask : rdChk
	task automatic irqChk(logic exp);
		bus(0, 0, 0, 0);
		#1 chk("irq", {31'h0000_0000, exp}, {31'h0000_0000, irq});
	endtask : irqChk
	task automatic t_start();
		rdChk("preset", `SCIF_OFF_FLAGS, 32'h0000_0004);
		rdChk("enable", `SCIF_OFF_ENCLR, 32'h0000_0000);
		rdChk("unmapped", 8'h10, 32'h0000_0000);
		bus(1, 0, `SCIF_OFF_FLAGS, 32'h0000_0004);
		rdChk("cleared", `SCIF_OFF_FLAGS, 32'h0000_0000);
	endtask : t_start
	// Walk every bit: implemented ones latch, reserved ones never show
	task automatic t_bits();
		logic [31:0] v;
		for (int i = 0; i < 32; i++) begin
			v = 32'h0000_0001 << i;
			@(posedge clk) liveStatus <= v;
			rdChk("flag", `SCIF_OFF_FLAGS, v & `SCIF_IMPL_MASK);
			rdChk("live", `SCIF_OFF_LIVE, v & `SCIF_IMPL_MASK);
			bus(1, 0, `SCIF_OFF_FLAGS, v & `SCIF_IMPL_MASK);
			rdChk("clear", `SCIF_OFF_FLAGS, 32'h0000_0000);
			@(posedge clk) liveStatus <= 32'h0000_0000;
		end
	endtask : t_bits
	task automatic t_irq();
		bus(1, 0, `SCIF_OFF_ENSET, 32'h0000_0001);
		rdChk("enable", `SCIF_OFF_ENCLR, 32'h0000_0001);
		bus(1, 0, `SCIF_OFF_ENSET, 32'h0000_0000);
		rdChk("enable", `SCIF_OFF_ENSET, 32'h0000_0001);
		irqChk(0);
		@(posedge clk) liveStatus <= 32'h0000_0001;
		bus(0, 1, `SCIF_OFF_FLAGS, 0);
		bus(1, 0, `SCIF_OFF_FLAGS, 0);
		rdChk("kept", `SCIF_OFF_FLAGS, 32'h0000_0001);
		irqChk(1);
		bus(1, 0, `SCIF_OFF_FLAGS, 32'h0000_0001);
		irqChk(0);
		bus(1, 0, `SCIF_OFF_ENCLR, 32'h0000_0001);
		rdChk("disabled", `SCIF_OFF_ENSET, 32'h0000_0000);
		@(posedge clk) liveStatus <= 32'h0000_0003;
		irqChk(0);
		bus(0, 1, `SCIF_OFF_FLAGS, 0);
		bus(1, 0, `SCIF_OFF_ENSET, `SCIF_IMPL_MASK);
		irqChk(1);
		bus(1, 0, `SCIF_OFF_FLAGS, `SCIF_IMPL_MASK);
		irqChk(0);
	endtask : t_irq
	// Clear and rising status land on the same edge
	task automatic t_race();
		bus(1, 0, `SCIF_OFF_FLAGS, 32'h0000_0008);
		liveStatus <= 32'h0000_000B;
		rdChk("race", `SCIF_OFF_FLAGS, 32'h0000_0008);
	endtask : t_race
	initial begin
		{nrst, wr, rd, addr, wdata, liveStatus} = '0;
		startupFlags = 32'h0000_0004;
		repeat (2) @(posedge clk);
		nrst <= 1;
		t_start();
		t_bits();
		t_irq();
		t_race();
		summarize();
	end
endmodule : sysctrl_interrupt_flags_tb_top

`default_nettype wire
